/* verif/pac_core_assertions.sv */
// concurrent checks on the negotiation config block ports
`timescale 1ns/1ps
module pac_core_assertions (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic [5:0] addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [15:0] rdata_o,
    input wire logic [1:0] media_strap_i,
    input wire logic [1:0] negotiation_enable_strap_i,
    input wire logic [1:0] ability_strap_high_i,
    input wire logic [1:0] ability_strap_low_i,
    input wire logic [1:0] rx_page_valid_i,
    input wire logic [1:0][15:0] rx_page_word_i,
    input wire logic [1:0] link10_good_i,
    input wire logic [1:0] link100_good_i,
    input wire logic [1:0] flp_enable_o,
    input wire logic [1:0][15:0] adv_word_o,
    input wire logic [1:0] fiber_mode_o,
    input wire logic [1:0] far_end_fault_en_o,
    input wire logic [1:0] scrambler_bypass_o,
    input wire logic [1:0] descrambler_bypass_o,
    input wire logic [1:0] speed100_o,
    input wire logic [1:0] full_duplex_o,
    input wire logic [1:0] link_up_o,
    input wire logic [1:0] negotiation_done_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (reset_i);
    rdata_idle_a: assert property (!rd_i |=> rdata_o == 16'h0000)
        else $error("read data not zero outside a read");
    status_const_a: assert property (rd_i && addr_i[4:0] == 5'h01 |=> (rdata_o & 16'hffcb) == 16'h7849)
        else $error("basic status constant bits wrong");
    pcs_read_a: assert property (rd_i && addr_i == 6'h36 |=> rdata_o == {9'h000, fiber_mode_o[1], 2'b00,
        far_end_fault_en_o[1], 1'b0, scrambler_bypass_o[1], descrambler_bypass_o[1]})
        else $error("pcs readback differs from outputs");
    neg_restart_a: assert property (wr_i && addr_i == 6'h00 && wdata_i[12] && wdata_i[9] && !fiber_mode_o[0]
        |=> ##[0:1] flp_enable_o[0] && !negotiation_done_o[0])
        else $error("restart did not begin negotiation");
    pd_mode_a: assert property (flp_enable_o[0] && link100_good_i[0] && !link10_good_i[0] && !rx_page_valid_i[0]
        |=> !negotiation_done_o[0] || (speed100_o[0] && !full_duplex_o[0]))
        else $error("parallel detect mode wrong");
    adv_write_a: assert property (wr_i && addr_i == 6'h04 |=>
        adv_word_o[0] == (($past(wdata_i) & 16'h01e0) | 16'h0001))
        else $error("advertised word not updated");
    forced_mode_a: assert property (wr_i && addr_i == 6'h20 && !wdata_i[12] && !fiber_mode_o[1] |=>
        ($past(wdata_i) & 16'h2100) == {2'b00, speed100_o[1], 4'h0, full_duplex_o[1], 8'h00})
        else $error("forced speed or duplex wrong");
    media_hold_a: assert property ($changed(fiber_mode_o) |-> $past(wr_i) || $past(reset_i, 2) || $past(reset_i, 3))
        else $error("media changed without write or reset");
    done_quiet_a: assert property (negotiation_done_o[0] |-> !flp_enable_o[0])
        else $error("pulses sent after completion");
endmodule
bind pac_core pac_core_assertions i_pac_core_assertions (.*);

/* verif/pac_link_partner.sv */
// far-end link partner model for one port
`timescale 1ns/1ps
module pac_link_partner (
    input wire logic clk_i,
    output logic page_valid_o,
    output logic [15:0] page_word_o,
    output logic link10_o,
    output logic link100_o
);
    initial begin
        page_valid_o = 1'b0;
        page_word_o = 16'h0000;
        link10_o = 1'b0;
        link100_o = 1'b0;
    end
    // one code word, then the word lines show its inverse
    task automatic send(input logic [15:0] w, input logic l10, input logic l100);
        @(posedge clk_i);
        page_valid_o <= 1'b1;
        page_word_o <= w;
        link10_o <= l10;
        link100_o <= l100;
        @(posedge clk_i);
        page_valid_o <= 1'b0;
        page_word_o <= ~w;
    endtask
    // link signals only: a partner that does not negotiate
    task automatic links(input logic l10, input logic l100);
        @(posedge clk_i);
        link10_o <= l10;
        link100_o <= l100;
    endtask
endmodule

/* verif/tb_pac_core.sv */
// self-checking bench for the negotiation config block
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin n_mismatch++; $display("[ERR] %s exp %h got %h", n, e, g); end end
module tb_pac_core;
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic [5:0] addr_i = '0;
    logic [15:0] wdata_i = '0;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic rd_pend = 1'b0;
    logic [15:0] rdata_o, e_t;
    logic [1:0] media = '0, an_st = '0, ab_hi = '0, ab_lo = '0;
    logic [1:0] pv, l10, l100, flp, fib, fef, scr, dscr, spd, fdx, lnk, done;
    logic [1:0][15:0] pw, adv;
    logic [15:0] exp_q[$];
    string nm_q[$];
    string n_t;
    int n_mismatch = 0, n_checks = 0, seed = 70727, r;
    // adv, partner abilities, expected speed100 and full duplex
    logic [9:0] tab [5] = '{{4'hf, 4'hf, 2'b11}, {4'hf, 4'h7, 2'b10}, {4'hf, 4'h3, 2'b01},
        {4'hf, 4'h1, 2'b00}, {4'h3, 4'hf, 2'b01}};
    logic [3:0] advtab [4] = '{4'h3, 4'hc, 4'h5, 4'hf};
    always #2.5 clk_i = ~clk_i;
    pac_core i_pac_core (.clk_i(clk_i), .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
        .rd_i(rd_i), .rdata_o(rdata_o), .media_strap_i(media), .negotiation_enable_strap_i(an_st),
        .ability_strap_high_i(ab_hi), .ability_strap_low_i(ab_lo), .rx_page_valid_i(pv), .rx_page_word_i(pw),
        .link10_good_i(l10), .link100_good_i(l100), .flp_enable_o(flp), .adv_word_o(adv), .fiber_mode_o(fib),
        .far_end_fault_en_o(fef), .scrambler_bypass_o(scr), .descrambler_bypass_o(dscr), .speed100_o(spd),
        .full_duplex_o(fdx), .link_up_o(lnk), .negotiation_done_o(done));
    pac_link_partner p0 (.clk_i(clk_i), .page_valid_o(pv[0]), .page_word_o(pw[0]), .link10_o(l10[0]),
        .link100_o(l100[0]));
    pac_link_partner p1 (.clk_i(clk_i), .page_valid_o(pv[1]), .page_word_o(pw[1]), .link10_o(l10[1]),
        .link100_o(l100[1]));
    ////////////////////////////////////////////////////////////////
    task automatic wr(input logic [5:0] a, input logic [15:0] d);
        @(posedge clk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [5:0] a, input logic [15:0] e, input string n);
        exp_q.push_back(e);
        nm_q.push_back(n);
        @(posedge clk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge clk_i);
        rd_i <= 1'b0;
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge clk_i);
        @(negedge clk_i);
    endtask
    task automatic rst(input logic [1:0] m, input logic [1:0] h, input logic [1:0] l);
        @(posedge clk_i);
        reset_i <= 1'b1;
        media <= m;
        an_st <= 2'b01;
        ab_hi <= h;
        ab_lo <= l;
        repeat (2) @(posedge clk_i);
        reset_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        r = $random(seed);
        media <= r[1:0];
        an_st <= r[3:2];
        ab_hi <= r[5:4];
        ab_lo <= r[7:6];
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    always @(posedge clk_i) begin
        if (rd_pend) begin
            e_t = exp_q.pop_front();
            n_t = nm_q.pop_front();
            `CHK(n_t, e_t, rdata_o)
        end
        rd_pend <= rd_i;
    end
    initial begin
        #50000;
        n_mismatch++;
        conclude();
    end
    initial begin
        for (int k = 0; k < 4; k++) begin
            rst({k == 3, 1'b0}, {2{k[1]}}, {2{k[0]}});
            rd(6'h04, {7'h00, advtab[k], 5'h01}, "advertise");
            rd(6'h36, (k == 3) ? 16'h004b : 16'h0000, "pcs b");
            rd(6'h16, 16'h0000, "pcs a");
            `CHK("forced speed", k[1], spd[1])
            `CHK("forced duplex", k[0], fdx[1])
            `CHK("fiber pcs out", {3{k == 3}}, {fef[1], scr[1], dscr[1]})
            `CHK("flp on", 1'b1, flp[0])
            $display("strap test %0d done", k);
        end
        rd(6'h01, 16'h7849, "status idle");
        p0.send(16'ha1e1, 1'b0, 1'b1);
        p0.send(16'h2005, 1'b0, 1'b1);
        rd(6'h05, 16'h2005, "next page");
        rd(6'h01, 16'h787d, "status done");
        rd(6'h06, 16'h000b, "expansion");
        rd(6'h10, 16'h0015, "link status");
        $display("next page test done");
        for (int i = 0; i < 5; i++) begin
            p0.links(1'b0, 1'b0);
            wr(6'h04, {7'h00, tab[i][9:6], 5'h01});
            wr(6'h00, 16'h1200);
            p0.send({7'h00, tab[i][5:2], 5'h01}, !tab[i][1], tab[i][1]);
            wt(2);
            `CHK("res speed", tab[i][1], spd[0])
            `CHK("res duplex", tab[i][0], fdx[0])
            `CHK("res done", 1'b1, done[0])
        end
        rd(6'h06, 16'h0003, "expansion clr");
        $display("priority test done");
        for (int s = 0; s < 2; s++) begin
            p0.links(1'b0, 1'b0);
            wr(6'h00, 16'h1200);
            p0.links(s == 0, s == 1);
            wt(2);
            rd(6'h05, s ? 16'h0081 : 16'h0021, "pd partner");
            rd(6'h06, 16'h0000, "pd able");
            rd(6'h01, 16'h786d, "pd status");
            `CHK("pd speed", s == 1, spd[0])
            `CHK("pd link", 1'b1, lnk[0])
        end
        p0.links(1'b0, 1'b0);
        wr(6'h00, 16'h1200);
        p0.links(1'b1, 1'b1);
        wt(3);
        p0.links(1'b0, 1'b0);
        wt(4);
        rd(6'h06, 16'h0010, "pd fault held");
        rd(6'h06, 16'h0000, "pd fault clr");
        $display("parallel detect test done");
        wr(6'h36, 16'h0000);
        wr(6'h20, 16'h2100);
        wt(1);
        `CHK("b 100 full", 2'b11, {spd[1], fdx[1]})
        `CHK("a media", 1'b0, fib[0])
        wr(6'h20, 16'h0000);
        wt(1);
        `CHK("b 10 half", 2'b00, {spd[1], fdx[1]})
        wr(6'h20, 16'h3100);
        wt(2);
        `CHK("b neg on", 1'b1, flp[1])
        wr(6'h36, 16'h0040);
        wt(2);
        `CHK("b fiber", 2'b10, {fib[1], flp[1]})
        $display("forced mode test done");
        wt(2);
        conclude();
    end
endmodule

/* verilog/pac_core.sv */
// dual port media select, negotiation control and status registers
//
// The plain strobed port was decided locally.
`timescale 1ns/1ps
`include "pac_map.svh"
module pac_core
    import pac_pkg::*;
#(
    parameter logic LOCAL_NP_ABLE = 1'b0
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic [5:0] addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [15:0] rdata_o,
    input wire logic [1:0] media_strap_i,
    input wire logic [1:0] negotiation_enable_strap_i,
    input wire logic [1:0] ability_strap_high_i,
    input wire logic [1:0] ability_strap_low_i,
    input wire logic [1:0] rx_page_valid_i,
    input wire logic [1:0][15:0] rx_page_word_i,
    input wire logic [1:0] link10_good_i,
    input wire logic [1:0] link100_good_i,
    output logic [1:0] flp_enable_o,
    output logic [1:0][15:0] adv_word_o,
    output logic [1:0] fiber_mode_o,
    output logic [1:0] far_end_fault_en_o,
    output logic [1:0] scrambler_bypass_o,
    output logic [1:0] descrambler_bypass_o,
    output logic [1:0] speed100_o,
    output logic [1:0] full_duplex_o,
    output logic [1:0] link_up_o,
    output logic [1:0] negotiation_done_o
);

    // per-port fields plus the registered read word
    pac_state_s q, d;

    logic [1:0] st_load;
    logic [1:0] st_fiber;
    logic [1:0] st_negotiation_enable_strap;
    logic [1:0] st_speed;
    logic [1:0] st_dup;
    logic [1:0][3:0] st_adv;
    logic [1:0] rs_valid;
    logic [1:0] rs_speed;
    logic [1:0] rs_full;
    logic [1:0][3:0] common;

    ////////////////////////////////////////////////////////////////////////////////
    // per-port strap capture and resolution

    for (genvar g = 0; g < 2; g++) begin : g_port
        pac_strap_latch u_strap (
            .clk_i(clk_i),
            .reset_i(reset_i),
            .media_strap_i(media_strap_i[g]),
            .negotiation_enable_strap_i(negotiation_enable_strap_i[g]),
            .ability_strap_high_i(ability_strap_high_i[g]),
            .ability_strap_low_i(ability_strap_low_i[g]),
            .load_o(st_load[g]),
            .fiber_o(st_fiber[g]),
            .negotiation_enable_strap_o(st_negotiation_enable_strap[g]),
            .speed_o(st_speed[g]),
            .dup_o(st_dup[g]),
            .adv_o(st_adv[g])
        );

        // resolution uses the page on the wire in the cycle it is valid
        assign common[g] = q.port[g].adv & rx_page_word_i[g][`PAC_ADV_MSB:`PAC_ADV_LSB];

        pac_resolve u_resolve (
            .common_i(common[g]),
            .valid_o(rs_valid[g]),
            .speed100_o(rs_speed[g]),
            .full_o(rs_full[g])
        );
    end

    ////////////////////////////////////////////////////////////////////////////////
    // register read formatting

    function automatic logic [15:0] adv_word(input pac_port_s s);
        logic [15:0] w;
        w = 16'h0000;
        w[`PAC_ADV_MSB:`PAC_ADV_LSB] = s.adv;
        w[4:0] = `PAC_SELECTOR;
        return w;
    endfunction

    function automatic logic [15:0] read_reg(input pac_port_s s, input logic [4:0] a);
        logic [15:0] r;
        r = 16'h0000;
        case (a)
            `PAC_OFS_CONTROL: begin
                // restart bit is write-only and reads zero
                r[`PAC_CTL_SPEED] = s.speed;
                r[`PAC_CTL_NEGOTIATION_ENABLE_STRAP] = s.negotiation_enable_strap;
                r[`PAC_CTL_DUPLEX] = s.dup;
            end
            `PAC_OFS_STATUS: begin
                r = `PAC_STS_FIXED;
                r[`PAC_STS_COMPLETE] = s.complete;
                r[`PAC_STS_REMOTE_FAULT] = s.remote_fault;
                r[`PAC_STS_LINK] = s.link;
            end
            `PAC_OFS_ADVERTISE: begin
                r = adv_word(s);
            end
            `PAC_OFS_PARTNER: begin
                r = s.partner;
            end
            `PAC_OFS_EXPANSION: begin
                r[`PAC_EXP_PD_FAULT] = s.pd_fault;
                r[`PAC_EXP_PARTNER_NP] = s.partner_np;
                r[`PAC_EXP_LOCAL_NP] = LOCAL_NP_ABLE;
                r[`PAC_EXP_PAGE_RX] = s.page_rx;
                r[`PAC_EXP_PARTNER_ABLE] = s.partner_able;
            end
            `PAC_OFS_LINK_STATUS: begin
                r[`PAC_LST_LINK] = s.link;
                r[`PAC_LST_SPEED10] = s.link & ~s.res_speed;
                r[`PAC_LST_DUPLEX] = s.link & s.res_dup;
                r[`PAC_LST_COMPLETE] = s.complete;
            end
            `PAC_OFS_PCS: begin
                r[`PAC_PCS_FIBER] = s.fiber;
                r[`PAC_PCS_FEF] = s.fef;
                r[`PAC_PCS_SCR_BYPASS] = s.scr;
                r[`PAC_PCS_DSCR_BYPASS] = s.dscr;
            end
            default: r = 16'h0000;
        endcase
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        logic sel;
        logic start;
        logic line_ok;
        logic pd_one;
        d = q;
        sel = 1'b0;
        start = 1'b0;
        line_ok = 1'b0;
        pd_one = 1'b0;
        d.rdata = 16'h0000;
        if (rd_i) begin
            d.rdata = read_reg(q.port[addr_i[5]], addr_i[4:0]);
        end
        for (int p = 0; p < 2; p++) begin
            sel = (addr_i[5] == p[0]);
            start = 1'b0;

            // strap load once after reset release
            // values land two edges after reset release
            if (st_load[p]) begin
                d.port[p].fiber = st_fiber[p];
                d.port[p].fef = st_fiber[p];
                d.port[p].scr = st_fiber[p];
                d.port[p].dscr = st_fiber[p];
                d.port[p].negotiation_enable_strap = st_negotiation_enable_strap[p];
                d.port[p].speed = st_speed[p];
                d.port[p].dup = st_dup[p];
                d.port[p].adv = st_adv[p];
                start = st_negotiation_enable_strap[p];
            end

            // register writes
            // port chosen by address bit 5, same offsets on both ports
            if (wr_i && sel) begin
                case (addr_i[4:0])
                    `PAC_OFS_CONTROL: begin
                        d.port[p].speed = wdata_i[`PAC_CTL_SPEED];
                        d.port[p].negotiation_enable_strap = wdata_i[`PAC_CTL_NEGOTIATION_ENABLE_STRAP];
                        d.port[p].dup = wdata_i[`PAC_CTL_DUPLEX];
                        // a set enable starts from a cleared bit, or from a set one when the restart bit is also written
                        start = wdata_i[`PAC_CTL_NEGOTIATION_ENABLE_STRAP] & (~q.port[p].negotiation_enable_strap | wdata_i[`PAC_CTL_RESTART]);
                    end
                    `PAC_OFS_ADVERTISE: begin
                        d.port[p].adv = wdata_i[`PAC_ADV_MSB:`PAC_ADV_LSB];
                    end
                    `PAC_OFS_PCS: begin
                        d.port[p].fiber = wdata_i[`PAC_PCS_FIBER];
                        d.port[p].fef = wdata_i[`PAC_PCS_FEF];
                        d.port[p].scr = wdata_i[`PAC_PCS_SCR_BYPASS];
                        d.port[p].dscr = wdata_i[`PAC_PCS_DSCR_BYPASS];
                    end
                    default: begin
                    end
                endcase
            end

            // read side effects, before any set so a set wins
            if (rd_i && sel && addr_i[4:0] == `PAC_OFS_EXPANSION) begin
                d.port[p].pd_fault = 1'b0;
                d.port[p].page_rx = 1'b0;
            end

            // negotiation sequence
            // no break-link timer: a restart goes straight to ability exchange
            // fiber media never negotiates
            if (!d.port[p].negotiation_enable_strap || d.port[p].fiber) begin
                d.port[p].an = PAC_AN_IDLE;
                d.port[p].complete = 1'b0;
            end else if (start) begin
                d.port[p].an = PAC_AN_ABILITY;
                d.port[p].complete = 1'b0;
                d.port[p].pd_fault = 1'b0;
                d.port[p].partner_able = 1'b0;
                d.port[p].partner_np = 1'b0;
            end else begin
                case (q.port[p].an)
                    PAC_AN_IDLE: begin
                        d.port[p].an = PAC_AN_IDLE;
                    end
                    PAC_AN_ABILITY: begin
                        pd_one = link10_good_i[p] ^ link100_good_i[p];
                        if (rx_page_valid_i[p]) begin
                            d.port[p].partner = rx_page_word_i[p];
                            d.port[p].page_rx = 1'b1;
                            d.port[p].partner_able = 1'b1;
                            d.port[p].partner_np = rx_page_word_i[p][`PAC_PAGE_NEXT];
                            d.port[p].remote_fault = rx_page_word_i[p][`PAC_PAGE_REMOTE_FAULT];
                            d.port[p].res_speed = rs_speed[p];
                            d.port[p].res_dup = rs_full[p];
                            if (rx_page_word_i[p][`PAC_PAGE_NEXT]) begin
                                d.port[p].an = PAC_AN_NEXT;
                            end else if (rs_valid[p]) begin
                                d.port[p].an = PAC_AN_DONE;
                                d.port[p].complete = 1'b1;
                            end
                        // parallel detect only until a partner page has been seen
                        end else if (!q.port[p].partner_able && pd_one) begin
                            d.port[p].partner = link100_good_i[p] ? `PAC_PD_WORD_100 : `PAC_PD_WORD_10;
                            d.port[p].res_speed = link100_good_i[p];
                            d.port[p].res_dup = 1'b0;
                            d.port[p].partner_able = 1'b0;
                            d.port[p].complete = 1'b1;
                            d.port[p].an = PAC_AN_DONE;
                        end else if (!q.port[p].partner_able && link10_good_i[p] && link100_good_i[p]) begin
                            d.port[p].pd_fault = 1'b1;
                        end
                    end
                    PAC_AN_NEXT: begin
                        if (rx_page_valid_i[p]) begin
                            d.port[p].partner = rx_page_word_i[p];
                            d.port[p].page_rx = 1'b1;
                            if (!rx_page_word_i[p][`PAC_PAGE_NEXT]) begin
                                d.port[p].an = PAC_AN_DONE;
                                d.port[p].complete = 1'b1;
                            end
                        end
                    end
                    PAC_AN_DONE: begin
                        line_ok = q.port[p].res_speed ? link100_good_i[p] : link10_good_i[p];
                        // lost link resumes negotiation
                        if (!line_ok) begin
                            d.port[p].an = PAC_AN_ABILITY;
                            d.port[p].complete = 1'b0;
                            d.port[p].partner_able = 1'b0;
                        end
                    end
                    default: begin
                        d.port[p].an = PAC_AN_IDLE;
                    end
                endcase
            end

            // resolved mode and link
            // forced mode: fiber always runs at 100
            if (d.port[p].an == PAC_AN_IDLE) begin
                d.port[p].res_speed = d.port[p].fiber | d.port[p].speed;
                d.port[p].res_dup = d.port[p].dup;
            end
            line_ok = d.port[p].res_speed ? link100_good_i[p] : link10_good_i[p];
            d.port[p].link = line_ok & (d.port[p].an == PAC_AN_IDLE || d.port[p].an == PAC_AN_DONE);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // state register
    // synchronous reset clears every port field

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // outputs
    // flp bursts only while pages are exchanged

    assign rdata_o = q.rdata;

    for (genvar o = 0; o < 2; o++) begin : g_out
        assign flp_enable_o[o] = (q.port[o].an == PAC_AN_ABILITY) || (q.port[o].an == PAC_AN_NEXT);
        assign adv_word_o[o] = adv_word(q.port[o]);
        assign fiber_mode_o[o] = q.port[o].fiber;
        assign far_end_fault_en_o[o] = q.port[o].fef;
        assign scrambler_bypass_o[o] = q.port[o].scr;
        assign descrambler_bypass_o[o] = q.port[o].dscr;
        assign speed100_o[o] = q.port[o].res_speed;
        assign full_duplex_o[o] = q.port[o].res_dup;
        assign link_up_o[o] = q.port[o].link;
        assign negotiation_done_o[o] = q.port[o].complete;
    end

endmodule

/* verilog/pac_map.svh */
// register offsets, field positions and reset values for the negotiation config block
`ifndef PAC_MAP_SVH
`define PAC_MAP_SVH

`define PAC_OFS_CONTROL 5'h00
`define PAC_OFS_STATUS 5'h01
`define PAC_OFS_ADVERTISE 5'h04
`define PAC_OFS_PARTNER 5'h05
`define PAC_OFS_EXPANSION 5'h06
`define PAC_OFS_LINK_STATUS 5'h10
`define PAC_OFS_PCS 5'h16

`define PAC_CTL_SPEED 13
`define PAC_CTL_NEGOTIATION_ENABLE_STRAP 12
`define PAC_CTL_RESTART 9
`define PAC_CTL_DUPLEX 8

`define PAC_ADV_LSB 5
`define PAC_ADV_MSB 8
`define PAC_SELECTOR 5'h01
`define PAC_PAGE_NEXT 15
`define PAC_PAGE_REMOTE_FAULT 13

`define PAC_STS_FIXED 16'h7849
`define PAC_STS_COMPLETE 5
`define PAC_STS_REMOTE_FAULT 4
`define PAC_STS_LINK 2

`define PAC_EXP_PD_FAULT 4
`define PAC_EXP_PARTNER_NP 3
`define PAC_EXP_LOCAL_NP 2
`define PAC_EXP_PAGE_RX 1
`define PAC_EXP_PARTNER_ABLE 0

`define PAC_LST_LINK 0
`define PAC_LST_SPEED10 1
`define PAC_LST_DUPLEX 2
`define PAC_LST_COMPLETE 4

`define PAC_PCS_FIBER 6
`define PAC_PCS_FEF 3
`define PAC_PCS_SCR_BYPASS 1
`define PAC_PCS_DSCR_BYPASS 0

`define PAC_PD_WORD_100 16'h0081
`define PAC_PD_WORD_10 16'h0021
`define PAC_ABIL_10_BOTH 4'h3
`define PAC_ABIL_100_BOTH 4'hc
`define PAC_ABIL_HALF_BOTH 4'h5
`define PAC_ABIL_ALL 4'hf

`endif

/* verilog/pac_pkg.sv */
// types shared by the negotiation config block
package pac_pkg;

    typedef enum logic [1:0] {
        PAC_AN_IDLE = 2'h0,
        PAC_AN_ABILITY = 2'h1,
        PAC_AN_NEXT = 2'h3,
        PAC_AN_DONE = 2'h2
    } pac_an_e;

    typedef struct packed {
        pac_an_e an;
        logic speed;
        logic negotiation_enable_strap;
        logic dup;
        logic [3:0] adv;
        logic [15:0] partner;
        logic fiber;
        logic fef;
        logic scr;
        logic dscr;
        logic complete;
        logic pd_fault;
        logic partner_np;
        logic page_rx;
        logic partner_able;
        logic remote_fault;
        logic res_speed;
        logic res_dup;
        logic link;
    } pac_port_s;

    typedef struct packed {
        pac_port_s [1:0] port;
        logic [15:0] rdata;
    } pac_state_s;

    typedef struct packed {
        logic armed;
        logic load;
        logic fiber;
        logic negotiation_enable_strap;
        logic speed;
        logic dup;
        logic [3:0] adv;
    } pac_strap_s;

endpackage

/* verilog/pac_resolve.sv */
// highest common ability picker
`timescale 1ns/1ps
module pac_resolve (
    input wire logic [3:0] common_i,
    output logic valid_o,
    output logic speed100_o,
    output logic full_o
);

    always_comb begin
        valid_o = 1'b1;
        speed100_o = 1'b0;
        full_o = 1'b0;
        if (common_i[3]) begin
            speed100_o = 1'b1;
            full_o = 1'b1;
        end else if (common_i[2]) begin
            speed100_o = 1'b1;
        end else if (common_i[1]) begin
            full_o = 1'b1;
        end else if (!common_i[0]) begin
            valid_o = 1'b0;
        end
    end

endmodule

/* verilog/pac_strap_latch.sv */
// one-time capture and decode of the media and negotiation straps of one port
`timescale 1ns/1ps
`include "pac_map.svh"
module pac_strap_latch
    import pac_pkg::*;
(
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic media_strap_i,
    input wire logic negotiation_enable_strap_i,
    input wire logic ability_strap_high_i,
    input wire logic ability_strap_low_i,
    output logic load_o,
    output logic fiber_o,
    output logic negotiation_enable_strap_o,
    output logic speed_o,
    output logic dup_o,
    output logic [3:0] adv_o
);

    pac_strap_s q, d;

    function automatic logic [3:0] advert(input logic an, input logic h, input logic l);
        logic [3:0] r;
        r = 4'h0;
        if (!an) begin
            r[{h, l}] = 1'b1;
        end else begin
            case ({h, l})
                2'b00: r = `PAC_ABIL_10_BOTH;
                2'b01: r = `PAC_ABIL_100_BOTH;
                2'b10: r = `PAC_ABIL_HALF_BOTH;
                default: r = `PAC_ABIL_ALL;
            endcase
        end
        return r;
    endfunction

    always_comb begin
        d = q;
        d.load = 1'b0;
        if (!q.armed) begin
            d.armed = 1'b1;
            d.load = 1'b1;
            d.fiber = media_strap_i;
            d.negotiation_enable_strap = negotiation_enable_strap_i;
            d.speed = ability_strap_high_i;
            d.dup = ability_strap_low_i;
            d.adv = advert(negotiation_enable_strap_i, ability_strap_high_i, ability_strap_low_i);
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign load_o = q.load;
    assign fiber_o = q.fiber;
    assign negotiation_enable_strap_o = q.negotiation_enable_strap;
    assign speed_o = q.speed;
    assign dup_o = q.dup;
    assign adv_o = q.adv;

endmodule
